// ### tacq_top.sv
// acquisition sequencing, switch control and result slots of the converter
// assumes an analog converter core that raises convDone with its result
`timescale 1ns/1ns
`default_nettype none
module tacq_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // register port
  input  wire logic [4:0]            busAddr,
  input  wire logic [11:0]           busWdata,
  input  wire logic                  busWr,
  input  wire logic                  busRd,
  output var  logic [11:0]           busRdata,
  // noise window pin
  input  wire logic                  acqInhibitIn,
  // converter core
  input  wire logic                  convDone,
  input  wire logic [11:0]           convResult,
  output var  logic                  convStart,
  output var  logic                  sampleTrack,
  output var  tacq_pkg::tacq_switch_t switchCfg,
  // status
  output var  logic                  busy
);
  tacq_pkg::tacq_state_t  state;
  tacq_pkg::tacq_state_t  next_state;
  tacq_pkg::tacq_switch_t next_switchCfg;
  tacq_pkg::tacq_switch_t chanSwitch;
  logic [11:0] controlOne;
  logic [11:0] controlTwo;
  logic [11:0] limitHigh;
  logic [11:0] limitLow;
  logic [1:0]  alertStatus;
  logic [11:0] results [16];
  logic [3:0]  channel;
  logic [3:0]  count;
  logic [3:0]  next_count;
  logic        next_convStart;
  logic        next_sampleTrack;
  logic [11:0] next_busRdata;

  // switch settings per channel
  function automatic tacq_pkg::tacq_switch_t chanCfg(input logic [3:0] ch,
                                                    input logic diff);
    tacq_pkg::tacq_switch_t c;
    c = tacq_pkg::SWITCH_OFF;
    case (ch)
      tacq_pkg::CH_YPOS:
      begin
        c.ypDrive   = 1'b1;
        c.ymDrive   = 1'b1;
        c.inSel     = tacq_pkg::IN_XP;
        c.refScreen = diff;
      end
      tacq_pkg::CH_XPOS:
      begin
        c.xpDrive   = 1'b1;
        c.xmDrive   = 1'b1;
        c.inSel     = tacq_pkg::IN_YP;
        c.refScreen = diff;
      end
      tacq_pkg::CH_PRESSURE_A:
      begin
        c.ypDrive   = 1'b1;
        c.xmDrive   = 1'b1;
        c.inSel     = tacq_pkg::IN_YM;
        c.refScreen = diff;
      end
      tacq_pkg::CH_PRESSURE_B:
      begin
        c.ypDrive   = 1'b1;
        c.xmDrive   = 1'b1;
        c.inSel     = tacq_pkg::IN_XP;
        c.refScreen = diff;
      end
      tacq_pkg::CH_DIODE_A:
      begin
        c.inSel = tacq_pkg::IN_DIODE;
      end
      tacq_pkg::CH_DIODE_B:
      begin
        c.inSel    = tacq_pkg::IN_DIODE;
        c.biasHigh = 1'b1;
      end
      default:
      begin
        c.inSel = tacq_pkg::IN_AUX;
      end
    endcase
    return c;
  endfunction

  // decoding
  wire diffMode   = !controlOne[tacq_pkg::REF_MODE_SELECT_BIT];
  wire polarity   = controlTwo[tacq_pkg::INHIBIT_POLARITY_BIT];
  wire [3:0] acqTime   = controlTwo[tacq_pkg::ACQ_TIME_LSB +: 4];
  wire [3:0] firstWait = controlTwo[tacq_pkg::FIRST_DELAY_LSB +: 4];
  wire writeOne   = busWr && (busAddr == tacq_pkg::CONTROL_ONE_OFS);
  wire writeTwo   = busWr && (busAddr == tacq_pkg::CONTROL_TWO_OFS);
  wire writeAlert = busWr && (busAddr == tacq_pkg::ALERT_STATUS_OFS);
  wire writeHigh  = busWr && (busAddr == tacq_pkg::LIMIT_HIGH_OFS);
  wire writeLow   = busWr && (busAddr == tacq_pkg::LIMIT_LOW_OFS);
  wire startReq   = writeOne && busWdata[tacq_pkg::START_BIT] && (state == tacq_pkg::ST_IDLE);
  wire [3:0] nextChannel = startReq ? busWdata[3:0] : channel;
  wire inhibitSync;
  wire inhibitActive = polarity ? inhibitSync : !inhibitSync;
  wire acqBlocked    = (state == tacq_pkg::ST_ACQ) && inhibitActive;
  wire storeNow      = (state == tacq_pkg::ST_STORE);
  wire touchChan     = chanSwitch.ypDrive || chanSwitch.xpDrive;
  wire aboveHigh;
  wire belowLow;
  wire diodeCheck    = storeNow && (channel == tacq_pkg::CH_DIODE_A);

  assign chanSwitch = chanCfg(nextChannel, diffMode);

  tacq_sync tacq_sync_inst (
    .clk     (clk),
    .rst     (rst),
    .asyncIn (acqInhibitIn),
    .syncOut (inhibitSync)
  );

  tacq_limit tacq_limit_inst (
    .check     (diodeCheck),
    .value     (results[tacq_pkg::CH_DIODE_A]),
    .limitHigh (limitHigh),
    .limitLow  (limitLow),
    .aboveHigh (aboveHigh),
    .belowLow  (belowLow)
  );

  // sequencer next state
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      tacq_pkg::ST_IDLE:
      begin
        next_count = tacq_pkg::COUNT_RST;
        if (startReq)
        begin
          next_state = tacq_pkg::ST_DELAY;
        end
      end
      tacq_pkg::ST_DELAY:
      begin
        // inhibit not looked at here
        if (count == firstWait)
        begin
          next_state = tacq_pkg::ST_ACQ;
          next_count = tacq_pkg::COUNT_RST;
        end
        else
        begin
          next_count = count + 4'h1;
        end
      end
      tacq_pkg::ST_ACQ:
      begin
        if (acqBlocked || !sampleTrack)
        begin
          next_count = tacq_pkg::COUNT_RST;
        end
        else if (count == acqTime)
        begin
          next_state = tacq_pkg::ST_CONV;
          next_count = tacq_pkg::COUNT_RST;
        end
        else
        begin
          next_count = count + 4'h1;
        end
      end
      tacq_pkg::ST_CONV:
      begin
        if (convDone)
        begin
          next_state = tacq_pkg::ST_STORE;
        end
      end
      tacq_pkg::ST_STORE:
      begin
        next_state = tacq_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = tacq_pkg::ST_IDLE;
        next_count = tacq_pkg::COUNT_RST;
      end
    endcase
  end

  // output next values
  always_comb
  begin
    next_switchCfg = tacq_pkg::SWITCH_OFF;
    if ((next_state == tacq_pkg::ST_DELAY) || (next_state == tacq_pkg::ST_ACQ))
    begin
      next_switchCfg = chanSwitch;
    end
    else if (next_state == tacq_pkg::ST_CONV)
    begin
      next_switchCfg = chanSwitch;
      if (!diffMode && touchChan)
      begin
        next_switchCfg.ypDrive = 1'b0;
        next_switchCfg.ymDrive = 1'b0;
        next_switchCfg.xpDrive = 1'b0;
        next_switchCfg.xmDrive = 1'b0;
      end
    end
  end

  assign next_convStart   = (state == tacq_pkg::ST_ACQ) && (next_state == tacq_pkg::ST_CONV);
  assign next_sampleTrack = (next_state == tacq_pkg::ST_ACQ) && !inhibitActive;

  // read data mux, unmapped reads return zero
  always_comb
  begin
    next_busRdata = 12'h000;
    if (busAddr[4])
    begin
      next_busRdata = results[busAddr[3:0]];
    end
    else
    begin
      case (busAddr)
        tacq_pkg::CONTROL_ONE_OFS:  next_busRdata = controlOne;
        tacq_pkg::CONTROL_TWO_OFS:  next_busRdata = controlTwo;
        tacq_pkg::ALERT_STATUS_OFS: next_busRdata = {10'h000, alertStatus};
        tacq_pkg::LIMIT_HIGH_OFS:   next_busRdata = limitHigh;
        tacq_pkg::LIMIT_LOW_OFS:    next_busRdata = limitLow;
        default:                    next_busRdata = 12'h000;
      endcase
    end
  end

  // sequencer and outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state       <= tacq_pkg::ST_IDLE;
      count       <= tacq_pkg::COUNT_RST;
      channel     <= 4'h0;
      convStart   <= 1'b0;
      sampleTrack <= 1'b0;
      switchCfg   <= tacq_pkg::SWITCH_OFF;
      busy        <= 1'b0;
      busRdata    <= 12'h000;
    end
    else
    begin
      state       <= next_state;
      count       <= next_count;
      channel     <= nextChannel;
      convStart   <= next_convStart;
      sampleTrack <= next_sampleTrack;
      switchCfg   <= next_switchCfg;
      busy        <= (next_state != tacq_pkg::ST_IDLE);
      busRdata    <= busRd ? next_busRdata : 12'h000;
    end
  end

  // control and limit registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      controlOne <= tacq_pkg::CONTROL_ONE_RST;
      controlTwo <= tacq_pkg::CONTROL_TWO_RST;
      limitHigh  <= tacq_pkg::LIMIT_HIGH_RST;
      limitLow   <= tacq_pkg::LIMIT_LOW_RST;
    end
    else
    begin
      if (writeOne)
      begin
        controlOne <= {busWdata[11], 1'b0, busWdata[9:0]};
      end
      if (writeTwo)
      begin
        controlTwo <= busWdata;
      end
      if (writeHigh)
      begin
        limitHigh <= busWdata;
      end
      if (writeLow)
      begin
        limitLow <= busWdata;
      end
    end
  end

  // sticky alerts, a new event wins over a clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alertStatus <= 2'b00;
    end
    else
    begin
      alertStatus <= (alertStatus & ~(writeAlert ? busWdata[1:0] : 2'b00))
                     | {belowLow, aboveHigh};
    end
  end

  // result slots, slot index is the channel code
  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_slot
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          results[i] <= tacq_pkg::RESULT_RST;
        end
        else if ((state == tacq_pkg::ST_CONV) && convDone && (channel == 4'(i)))
        begin
          results[i] <= convResult;
        end
      end
    end
  endgenerate

  // checks
  ref_mode_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_ACQ) && (switchCfg.ypDrive || switchCfg.xpDrive)
    |-> (switchCfg.refScreen == !controlOne[tacq_pkg::REF_MODE_SELECT_BIT]))
    else $error("reference mode does not follow control bit");

  single_ended_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_CONV) && controlOne[tacq_pkg::REF_MODE_SELECT_BIT]
    && $past(state == tacq_pkg::ST_CONV)
    |-> !(switchCfg.ypDrive || switchCfg.ymDrive || switchCfg.xpDrive || switchCfg.xmDrive))
    else $error("excitation left on in single-ended conversion");

  ratio_hold_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_CONV) && diffMode && $past(state == tacq_pkg::ST_CONV)
    && (channel == tacq_pkg::CH_YPOS)
    |-> switchCfg.ypDrive && switchCfg.ymDrive && (switchCfg.inSel == tacq_pkg::IN_XP))
    else $error("excitation dropped in ratiometric conversion");

  pressure_drive_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_ACQ) && $past(state == tacq_pkg::ST_ACQ)
    && (channel == tacq_pkg::CH_PRESSURE_A)
    |-> switchCfg.ypDrive && switchCfg.xmDrive && (switchCfg.inSel == tacq_pkg::IN_YM))
    else $error("wrong switches for first pressure sample");

  inhibit_stall_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_ACQ) && inhibitActive |=> !convStart && !sampleTrack)
    else $error("acquisition proceeded while inhibited");

  inhibit_restart_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_ACQ) && inhibitActive |=> (count == tacq_pkg::COUNT_RST))
    else $error("aborted acquisition did not restart");

  conv_ignore_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_CONV) && !convDone |=> (state == tacq_pkg::ST_CONV))
    else $error("conversion disturbed");

  result_slot_a: assert property (@(posedge clk) disable iff (rst)
    (state == tacq_pkg::ST_CONV) && convDone && (channel == tacq_pkg::CH_PRESSURE_A)
    |=> (results[tacq_pkg::PRESSURE_A_OFS[3:0]] == $past(convResult)))
    else $error("first pressure result misplaced");

  alert_set_a: assert property (@(posedge clk) disable iff (rst)
    aboveHigh |=> alertStatus[0])
    else $error("high alert not raised");
endmodule
`default_nettype wire

// ### tacq_pkg.sv
// constants, types and state codes of the touch converter acquisition control
// assumes one 25 MHz clock and a plain register port with 5-bit addresses
package tacq_pkg;

  // register offsets
  localparam logic [4:0] CONTROL_ONE_OFS  = 5'h01;
  localparam logic [4:0] CONTROL_TWO_OFS  = 5'h02;
  localparam logic [4:0] ALERT_STATUS_OFS = 5'h03;
  localparam logic [4:0] LIMIT_HIGH_OFS   = 5'h04;
  localparam logic [4:0] LIMIT_LOW_OFS    = 5'h05;
  localparam logic [4:0] PRESSURE_B_OFS   = 5'h12;
  localparam logic [4:0] DIODE_A_OFS      = 5'h18;
  localparam logic [4:0] DIODE_B_OFS      = 5'h19;
  localparam logic [4:0] PRESSURE_A_OFS   = 5'h1A;

  // field positions
  localparam int REF_MODE_SELECT_BIT  = 11;
  localparam int START_BIT            = 10;
  localparam int INHIBIT_POLARITY_BIT = 3;
  localparam int ACQ_TIME_LSB         = 4;
  localparam int FIRST_DELAY_LSB      = 8;

  // reset values
  localparam logic [11:0] CONTROL_ONE_RST = 12'h000;
  localparam logic [11:0] CONTROL_TWO_RST = 12'h000;
  localparam logic [11:0] LIMIT_HIGH_RST  = 12'hFFF;
  localparam logic [11:0] LIMIT_LOW_RST   = 12'h000;
  localparam logic [11:0] RESULT_RST      = 12'h000;
  localparam logic [3:0]  COUNT_RST       = 4'h0;

  // channel codes
  localparam logic [3:0] CH_PRESSURE_B = 4'h2;
  localparam logic [3:0] CH_AUX_FIRST  = 4'h3;
  localparam logic [3:0] CH_BAT_LAST   = 4'h7;
  localparam logic [3:0] CH_DIODE_A    = 4'h8;
  localparam logic [3:0] CH_DIODE_B    = 4'h9;
  localparam logic [3:0] CH_PRESSURE_A = 4'hA;
  localparam logic [3:0] CH_XPOS       = 4'hB;
  localparam logic [3:0] CH_YPOS       = 4'hC;

  // converter input selections
  localparam logic [2:0] IN_XP    = 3'h0;
  localparam logic [2:0] IN_YP    = 3'h1;
  localparam logic [2:0] IN_YM    = 3'h2;
  localparam logic [2:0] IN_DIODE = 3'h3;
  localparam logic [2:0] IN_AUX   = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DELAY = 3'b001,
    ST_ACQ   = 3'b010,
    ST_CONV  = 3'b011,
    ST_STORE = 3'b100
  } tacq_state_t;

  typedef struct packed {
    logic       ypDrive;
    logic       ymDrive;
    logic       xpDrive;
    logic       xmDrive;
    logic       refScreen;
    logic       biasHigh;
    logic [2:0] inSel;
  } tacq_switch_t;

  localparam tacq_switch_t SWITCH_OFF = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0};

endpackage

// ### tacq_sync.sv
// two-stage synchroniser for the acquisition-inhibit pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module tacq_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin and result
  input  wire logic asyncIn,
  output var  logic syncOut
);
  logic stageOne;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stageOne <= 1'b1;
      syncOut  <= 1'b1;
    end
    else
    begin
      stageOne <= asyncIn;
      syncOut  <= stageOne;
    end
  end
endmodule
`default_nettype wire

// ### tacq_limit.sv
// high and low limit comparison of one result
// assumes check is a one-cycle pulse beside a stable value
`timescale 1ns/1ns
`default_nettype none
module tacq_limit (
  // inputs
  input  wire logic        check,
  input  wire logic [11:0] value,
  input  wire logic [11:0] limitHigh,
  input  wire logic [11:0] limitLow,
  // flags
  output var  logic        aboveHigh,
  output var  logic        belowLow
);
  assign aboveHigh = check && (value > limitHigh);
  assign belowLow  = check && (value < limitLow);
endmodule
`default_nettype wire

// ### tacq_screen_model.sv
// partner model: converter core and lcd control signal on the noise pin
// assumes the bench drives lcdActive, polHigh and nextResult after rising edges
`timescale 1ns/1ns
`default_nettype none
module tacq_screen_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // stimulus from bench
  input  wire logic        lcdActive,
  input  wire logic        polHigh,
  input  wire logic [11:0] nextResult,
  // converter core side
  input  wire logic        convStart,
  output var  logic        convDone,
  output var  logic [11:0] convResult,
  // noise window pin
  output var  logic        acqInhibitIn
);
  int waitN;

  // pin never floats, idle level is the inactive one
  always_comb acqInhibitIn = lcdActive ? polHigh : !polHigh;

  // answers after 1 to 8 cycles, result bus toggles outside done
  always @(posedge clk)
  begin
    if (rst)
    begin
      waitN      <= 0;
      convDone   <= 1'b0;
      convResult <= 12'hFFF;
    end
    else
    begin
      convDone   <= (waitN == 1);
      convResult <= (waitN == 1) ? nextResult : ~convResult;
      if (convStart)
        waitN <= 1 + int'($urandom % 8);
      else if (waitN != 0)
        waitN <= waitN - 1;
    end
  end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the acquisition control block
// assumes the partner model stands in for converter core and lcd signal
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  logic [4:0]             busAddr = 5'h00;
  logic [11:0]            busWdata = 12'h000;
  logic                   busWr = 1'b0;
  logic                   busRd = 1'b0;
  logic [11:0]            busRdata;
  logic                   acqInhibitIn;
  logic                   convDone;
  logic [11:0]            convResult;
  logic                   convStart;
  logic                   sampleTrack;
  logic                   busy;
  tacq_pkg::tacq_switch_t switchCfg;
  logic                   polHigh = 1'b0;
  logic                   noiseHold = 1'b0;
  logic                   burstOn = 1'b0;
  logic                   hit = 1'b0;
  logic [2:0]             noiseCnt = 3'h0;
  logic [11:0]            nextResult = 12'h000;
  logic                   rdPend = 1'b0;
  logic [11:0]            trackRun = 12'h000;
  logic [11:0]            trackCount = 12'h000;
  logic [11:0]            acqExp = 12'h000;
  logic [11:0]            snap;
  logic [17:0]            swNote;
  logic [16:0]            rdNote;
  logic [16:0]            rq[$];
  logic [17:0]            sq[$];
  logic [11:0]            tq[$];
  int                     miscompares = 0;
  int                     checksDone = 0;
  int                     seedVal;
  wire                    lcdActive = noiseHold || (noiseCnt != 3'h0);

  tacq_top tacq_top_inst (.clk(clk), .rst(rst), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .acqInhibitIn(acqInhibitIn),
    .convDone(convDone), .convResult(convResult), .convStart(convStart),
    .sampleTrack(sampleTrack), .switchCfg(switchCfg), .busy(busy));
  tacq_screen_model tacq_screen_model_inst (.clk(clk), .rst(rst), .lcdActive(lcdActive),
    .polHigh(polHigh), .nextResult(nextResult), .convStart(convStart), .convDone(convDone),
    .convResult(convResult), .acqInhibitIn(acqInhibitIn));

  always #20 clk = ~clk;

  task automatic compare(input string what, input logic [11:0] exp, input logic [11:0] got);
    checksDone++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [11:0] d);
    @(posedge clk);
    busAddr  <= a;
    busWdata <= d;
    busWr    <= 1'b1;
    @(posedge clk);
    busWr    <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [11:0] exp);
    @(posedge clk);
    busAddr <= a;
    busRd   <= 1'b1;
    rq.push_back({a, exp});
    @(posedge clk);
    busRd   <= 1'b0;
  endtask

  // expected switch pattern and care mask per channel
  function automatic logic [17:0] expOf(input logic [3:0] ch, input logic se);
    case (ch)
      tacq_pkg::CH_PRESSURE_A: return {se ? 4'b0000 : 4'b1001, 2'b00, tacq_pkg::IN_YM, 9'h1EF};
      tacq_pkg::CH_PRESSURE_B: return {se ? 4'b0000 : 4'b1001, 2'b00, tacq_pkg::IN_XP, 9'h1EF};
      tacq_pkg::CH_DIODE_A:    return {6'h00, tacq_pkg::IN_DIODE, 9'h00F};
      tacq_pkg::CH_DIODE_B:    return {6'h01, tacq_pkg::IN_DIODE, 9'h00F};
      tacq_pkg::CH_YPOS:       return {se ? 6'h00 : 6'h32, tacq_pkg::IN_XP, 9'h1FF};
      tacq_pkg::CH_XPOS:       return {se ? 6'h00 : 6'h0E, tacq_pkg::IN_YP, 9'h1FF};
      default:                 return {6'h00, tacq_pkg::IN_AUX, 9'h00F};
    endcase
  endfunction

  task automatic setCtl(input logic inhibit_polarity);
    logic [11:0] v;
    v = {4'($urandom % 16), 4'(7 + $urandom % 9), inhibit_polarity, 3'h0};
    acqExp = 12'(v[7:4]) + 12'h001;
    wr(tacq_pkg::CONTROL_TWO_OFS, v);
    polHigh <= inhibit_polarity;
    rd(tacq_pkg::CONTROL_TWO_OFS, v);
  endtask

  task automatic start(input logic [3:0] ch, input logic se, input logic [11:0] res);
    nextResult <= res;
    sq.push_back(expOf(ch, se));
    tq.push_back(acqExp);
    wr(tacq_pkg::CONTROL_ONE_OFS, {se, 1'b1, 6'h00, ch});
  endtask

  task automatic waitRead(input logic [3:0] ch, input logic [11:0] res);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 2000);
    if (busy !== 1'b0)
      miscompares++;
    rd({1'b1, ch}, res);
  endtask

  task automatic conv(input logic [3:0] ch, input logic se, input logic [11:0] res);
    start(ch, se, res);
    waitRead(ch, res);
  endtask

  // one abort burst inside each acquisition, one inside each conversion
  always @(posedge clk)
  begin
    if (noiseCnt != 3'h0)
      noiseCnt <= noiseCnt - 3'h1;
    else if (burstOn && ((sampleTrack && trackRun == 12'h002 && !hit) || convStart))
      noiseCnt <= 3'h4;
    if (convStart)
      hit <= 1'b0;
    else if (sampleTrack && trackRun == 12'h002)
      hit <= 1'b1;
  end

  // result watcher: takes the oldest note whenever a result shows
  always @(posedge clk)
  begin
    rdPend   <= busRd;
    trackRun <= sampleTrack ? trackRun + 12'h001 : 12'h000;
    if (sampleTrack)
      trackCount <= trackCount + 12'h001;
    if (rdPend)
    begin
      rdNote = rq.pop_front();
      compare($sformatf("reg %h", rdNote[16:12]), rdNote[11:0], busRdata);
    end
    if (convStart)
    begin
      swNote = sq.pop_front();
      compare("track cycles", tq.pop_front(), trackRun);
      compare("switch select", {7'h00, swNote[13:9] & swNote[4:0]},
        {7'h00, switchCfg[4:0] & swNote[4:0]});
    end
    if (convDone)
      compare("drives in conversion", {8'h00, swNote[17:14] & swNote[8:5]},
        {8'h00, switchCfg[8:5] & swNote[8:5]});
  end

  initial
  begin
    seedVal = $urandom(40757);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(tacq_pkg::CONTROL_TWO_OFS, 12'h000);
    wr(5'h00, 12'hABC);
    rd(5'h00, 12'h000);
    setCtl(1'b0);
    noiseHold <= 1'b1;
    start(tacq_pkg::CH_YPOS, 1'b0, 12'h5A5);
    @(negedge clk);
    snap = trackCount;
    repeat (30) @(negedge clk);
    compare("track while inhibited", snap, trackCount);
    compare("busy while inhibited", 12'h001, {11'h000, busy});
    @(posedge clk);
    noiseHold <= 1'b0;
    waitRead(tacq_pkg::CH_YPOS, 12'h5A5);
    wr(tacq_pkg::LIMIT_HIGH_OFS, 12'h100);
    wr(tacq_pkg::LIMIT_LOW_OFS, 12'h050);
    conv(tacq_pkg::CH_DIODE_B, 1'b0, 12'hFFF);
    rd(tacq_pkg::ALERT_STATUS_OFS, 12'h000);
    conv(tacq_pkg::CH_DIODE_A, 1'b0, 12'h200);
    rd(tacq_pkg::ALERT_STATUS_OFS, 12'h001);
    wr(tacq_pkg::ALERT_STATUS_OFS, 12'h001);
    conv(tacq_pkg::CH_DIODE_A, 1'b0, 12'h010);
    rd(tacq_pkg::ALERT_STATUS_OFS, 12'h002);
    wr(tacq_pkg::DIODE_A_OFS, 12'hABC);
    rd(tacq_pkg::DIODE_A_OFS, 12'h010);
    for (int p = 0; p < 2; p++)
    begin
      setCtl(p[0]);
      burstOn <= 1'b1;
      for (int c = 2; c < 13; c++)
        conv(c[3:0], 1'($urandom % 2), 12'($urandom));
    end
    repeat (3) @(posedge clk);
    stopTest();
  end

  initial
  begin
    #(40 * 20000);
    miscompares++;
    stopTest();
  end
endmodule
`default_nettype wire
